// ### bench/core_model.sv
// core model: issues store and load program requests to the guard
// assumes the guard samples requests on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic   clk,
  output logic [12:0] exec_addr,
  output logic        store_req,
  output logic        load_req,
  output logic [12:0] target_addr,
  output logic        read_en
);
  // idle core runs from the loader region
  initial begin
    exec_addr = 13'h1f10;
    store_req = 1'b0;
    load_req = 1'b0;
    target_addr = 13'h0000;
    read_en = 1'b0;
  end
  // one-cycle request; the address is scrambled after it so no stale value is trusted
  task automatic req(input logic st, input logic [12:0] ex, input logic [12:0] tgt);
    @(negedge clk);
    exec_addr = ex;
    target_addr = tgt;
    store_req = st;
    load_req = !st;
    @(negedge clk);
    store_req = 1'b0;
    load_req = 1'b0;
    target_addr = ~tgt;
  endtask
  // issued only after the operation is over
  task automatic clr();
    @(negedge clk);
    read_en = 1'b1;
    @(negedge clk);
    read_en = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// testbench for the flash self-program guard
// assumes the core model drives the request side off the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_guard_pkg::*;
  localparam logic [12:0] LDR = 13'h1f10;
  localparam logic [12:0] APP = 13'h0100;
  logic clock = 1'b0, srst = 1'b1, lock_set = 1'b0, chip_erase = 1'b0;
  logic gen_wr = 1'b0, gen_rw = 1'b0, vec_ldr = 1'b0;
  logic [1:0] fuses = 2'h3, set_app = 2'h3, set_boot = 2'h3, app_lock, boot_lock;
  logic [12:0] exec_addr, target_addr;
  logic store_req, load_req, read_en, start, grant, blocked, stall, busy, irq_mask;
  int fail_count = 0;
  int tests_run = 0;
  // 100 MHz clock
  always #5 clock = ~clock;
  core_model i_core_model (.clk(clock), .exec_addr(exec_addr), .store_req(store_req),
    .load_req(load_req), .target_addr(target_addr), .read_en(read_en));
  flash_self_program_guard i_flash_self_program_guard (.CLOCK(clock), .SRST(srst),
    .BOOT_SIZE_FUSES(fuses), .EXEC_ADDR(exec_addr), .STORE_REQ(store_req),
    .LOAD_REQ(load_req), .TARGET_ADDR(target_addr), .RWW_READ_ENABLE(read_en),
    .LOCK_SET(lock_set), .LOCK_SET_APP(set_app), .LOCK_SET_BOOT(set_boot),
    .CHIP_ERASE(chip_erase), .GENERAL_LOCK_WRITE(gen_wr), .GENERAL_LOCK_RW(gen_rw),
    .VECTORS_IN_LOADER(vec_ldr), .PROG_START(start), .LOAD_GRANT(grant),
    .LOAD_BLOCKED(blocked), .CORE_STALL(stall), .RWW_BUSY_FLAG(busy),
    .IRQ_MASK(irq_mask), .APP_LOCK(app_lock), .BOOT_LOCK(boot_lock));
  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // store request; a started one is run out and busy cleared afterwards
  task automatic op(input logic [12:0] ex, tgt, input logic go, halt);
    i_core_model.req(1'b1, ex, tgt);
    chk(start === go, "start pulse");
    if (go) begin
      chk(stall === halt, "stall level");
      repeat (380) @(negedge clock);
      chk(stall === halt, "stall held");
      if (!halt) begin
        chk(busy === 1'b1, "busy during op");
        i_core_model.req(1'b1, LDR, APP);
        chk(start === 1'b0, "store during op");
      end
      repeat (30) @(negedge clock);
      chk(stall === 1'b0, "stall end");
      i_core_model.clr();
      chk(busy === 1'b0, "busy cleared");
    end
  endtask
  task automatic ld(input logic [12:0] ex, tgt, input logic blk);
    i_core_model.req(1'b0, ex, tgt);
    chk(blocked === blk && grant === !blk, "load answer");
  endtask
  // erase then program both lock sets
  task automatic locks(input logic [1:0] a, b);
    @(negedge clock) chip_erase = 1'b1;
    @(negedge clock) chip_erase = 1'b0;
    lock_set = 1'b1;
    set_app = a;
    set_boot = b;
    @(negedge clock) lock_set = 1'b0;
    @(negedge clock) chk(app_lock === a && boot_lock === b, "lock value");
  endtask
  // long ops dominate; the 10 of them run here (about 4200 cycles) fit well inside this span
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (12) @(negedge clock);
    srst = 1'b0;
    chk(start === 1'b0 && stall === 1'b0 && busy === 1'b0, "reset out");
    chk(app_lock === LOCK_RESET && boot_lock === LOCK_RESET, "reset locks");
    op(LDR, APP, 1'b1, 1'b0);
    op(LDR, LDR, 1'b1, 1'b1);
    op(APP, APP, 1'b0, 1'b0);
    for (int f = 0; f < 4; f++) begin
      fuses = f[1:0];
      op(f == 3 ? 13'h1f00 : f == 2 ? 13'h1e00 : 13'h1c00, APP, 1'b1, 1'b0);
      op(f == 3 ? 13'h1eff : f == 2 ? 13'h1dff : 13'h1bff, APP, 1'b0, 1'b0);
    end
    fuses = 2'h3;
    for (int m = 0; m < 4; m++) begin
      locks(m[1:0], 2'h3);
      gen_wr = m[0];
      gen_rw = m[1];
      op(LDR, APP, m[0], 1'b0);
      ld(LDR, APP, !m[1]);
      vec_ldr = 1'b1;
      ld(APP, APP, 1'b0);
      @(negedge clock) chk(irq_mask === !m[1], "irq mask app");
      vec_ldr = 1'b0;
      locks(2'h3, m[1:0]);
      op(LDR, LDR, m[0], 1'b1);
      ld(APP, LDR, !m[1]);
      ld(LDR, LDR, 1'b0);
      @(negedge clock) chk(irq_mask === !m[1], "irq mask ldr");
    end
    locks(2'h2, 2'h3);
    lock_set = 1'b1;
    set_app = 2'h1;
    @(negedge clock) lock_set = 1'b0;
    @(negedge clock) chk(app_lock === 2'h0, "locks only program");
    end_of_test();
  end
endmodule
`default_nettype wire

// ### hw/flash_guard_pkg.sv
// constants for the flash self-program guard
// assumes word addressing of a 16 kbyte program flash (8k words)
package flash_guard_pkg;
  localparam int ADDR_W = 13;
  localparam logic [12:0] HALT_REGION_START = 13'h1c00; // fixed concurrent/halting split
  localparam logic [12:0] BOOT_START_256 = 13'h1f00;
  localparam logic [12:0] BOOT_START_512 = 13'h1e00;
  localparam logic [12:0] BOOT_START_1K = 13'h1c00;
  localparam logic [12:0] BOOT_START_2K = 13'h1c00; // clamped: loader stays in halting region
  localparam logic [1:0] LOCK_RESET = 2'h3; // unprogrammed
  localparam logic [1:0] BOOT_SIZE_RESET = 2'h0;
  localparam int OP_TIME_US = 4;
  localparam int CLK_MHZ = 100;
  localparam logic [9:0] OP_CYCLES = 10'(OP_TIME_US * CLK_MHZ);
  typedef enum logic [1:0] {ST_IDLE, ST_PROG_CONC, ST_PROG_HALT} prog_state_t;
endpackage

// ### hw/flash_self_program_guard.sv
// self-program guard: lock checks and read-while-write arbitration
// assumes the core presents one store or load request per pulse
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RL1] store from application code never programs
// [RL2] store from loader code may program anywhere
// [RL3] boot size fuses set loader boundary
// [RL4] concurrent region programming does not stall
// [RL5] halting region programming stalls core, no reads
// [RL6] software avoids concurrent region while busy
// [RL7] busy flag reads one while blocked
// [RL8] software clears busy before concurrent fetch
// [RL9] loader always inside halting region
// [RL10] two independent two-bit lock settings
// [RL11] locks only program; chip erase restores
// [RL12] general lock modes ignored for self-program
// [RL13] app locks 11: no restriction
// [RL14] app locks 10: block app writes
// [RL15] app locks 00: block writes and loader reads
// [RL16] app locks 01: block loader reads only
// [RL17] app read-locks mask interrupts from application
// [RL18] boot locks 11: no restriction
// [RL19] boot locks 10: block loader writes
// [RL20] boot locks 00: block writes and app reads
// [RL21] boot locks 01: block app reads only
// [RL22] boot read-locks mask interrupts from loader
// [RL23] software clears busy via read enable command
// [RL24] blocked accesses change nothing, return nothing
module flash_self_program_guard
  import flash_guard_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic [1:0]  BOOT_SIZE_FUSES,
  input  wire logic [12:0] EXEC_ADDR,
  input  wire logic        STORE_REQ,
  input  wire logic        LOAD_REQ,
  input  wire logic [12:0] TARGET_ADDR,
  input  wire logic        RWW_READ_ENABLE,
  input  wire logic        LOCK_SET,
  input  wire logic [1:0]  LOCK_SET_APP,
  input  wire logic [1:0]  LOCK_SET_BOOT,
  input  wire logic        CHIP_ERASE,
  input  wire logic        GENERAL_LOCK_WRITE,
  input  wire logic        GENERAL_LOCK_RW,
  input  wire logic        VECTORS_IN_LOADER,
  output logic             PROG_START,
  output logic             LOAD_GRANT,
  output logic             LOAD_BLOCKED,
  output logic             CORE_STALL,
  output logic             RWW_BUSY_FLAG,
  output logic             IRQ_MASK,
  output logic [1:0]       APP_LOCK,
  output logic [1:0]       BOOT_LOCK
);
  logic exec_loader, exec_halting, tgt_loader, tgt_halting;
  prog_state_t state, next_state;
  logic [9:0]  count, next_count;
  logic [1:0]  next_app_lock, next_boot_lock;
  logic        next_busy, next_stall, next_start, next_lgrant, next_lblock, next_irq;
  logic        store_ok, load_ok;

  // executing address and target address classification
  region_decode exec_dec (
    .boot_size  (BOOT_SIZE_FUSES),
    .addr       (EXEC_ADDR),
    .in_loader  (exec_loader),
    .in_halting (exec_halting)
  ); // [RL3] [RL9]
  region_decode tgt_dec (
    .boot_size  (BOOT_SIZE_FUSES),
    .addr       (TARGET_ADDR),
    .in_loader  (tgt_loader),
    .in_halting (tgt_halting)
  );

  // lock pair is {hi,lo}; a programmed (zero) lo bit forbids stores
  function automatic logic write_locked(input logic [1:0] lock);
    return (lock[0] == 1'b0);
  endfunction

  // a programmed (zero) hi bit forbids reads from the other region's code
  function automatic logic read_locked(input logic [1:0] lock);
    return (lock[1] == 1'b0);
  endfunction

  // lock policy; general lock inputs deliberately unused [RL12]
  always_comb begin
    store_ok = exec_loader; // [RL1] [RL2]
    if (tgt_loader) begin
      if (write_locked(BOOT_LOCK))
        store_ok = 1'b0; // [RL19] [RL20]
    end else begin
      if (write_locked(APP_LOCK))
        store_ok = 1'b0; // [RL14] [RL15]
    end
    load_ok = 1'b1; // [RL13] [RL18]
    if (exec_loader && !tgt_loader && read_locked(APP_LOCK))
      load_ok = 1'b0; // [RL15] [RL16]
    if (!exec_loader && tgt_loader && read_locked(BOOT_LOCK))
      load_ok = 1'b0; // [RL20] [RL21]
  end

  // next state for sequencer, busy flag, locks and strobes
  always_comb begin
    next_state     = state;
    next_count     = count;
    next_busy      = RWW_BUSY_FLAG;
    next_start     = 1'b0;
    next_lgrant    = 1'b0;
    next_lblock    = 1'b0;
    next_app_lock  = APP_LOCK;
    next_boot_lock = BOOT_LOCK;
    // locks only move toward programmed; erase or SRST is the only way back [RL10] [RL11]
    if (CHIP_ERASE) begin
      next_app_lock  = LOCK_RESET;
      next_boot_lock = LOCK_RESET;
    end else if (LOCK_SET) begin
      next_app_lock  = APP_LOCK & LOCK_SET_APP;
      next_boot_lock = BOOT_LOCK & LOCK_SET_BOOT;
    end
    case (state)
      ST_IDLE: begin
        if (STORE_REQ && store_ok) begin
          next_start = 1'b1;
          next_count = OP_CYCLES;
          if (tgt_halting) begin
            next_state = ST_PROG_HALT; // [RL5]
          end else begin
            next_state = ST_PROG_CONC; // [RL4]
            next_busy  = 1'b1; // [RL7]
          end
        end else if (LOAD_REQ) begin
          next_lgrant = load_ok;
          next_lblock = !load_ok; // [RL24]
        end
        // clear of busy flag only when idle, so a new set always wins [RL23]
        if (RWW_READ_ENABLE && !(STORE_REQ && store_ok && !tgt_halting))
          next_busy = 1'b0;
      end
      default: begin
        next_count = count - 10'h001;
        if (count == 10'h001)
          next_state = ST_IDLE;
      end
    endcase
    next_stall = (next_state == ST_PROG_HALT); // [RL5]
    // interrupt mask when vectors sit in the other region and the executing region is read-protected
    next_irq = (VECTORS_IN_LOADER && !exec_loader && read_locked(APP_LOCK)) ||
               (!VECTORS_IN_LOADER && exec_loader && read_locked(BOOT_LOCK)); // [RL17] [RL22]
  end

  // registers
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state         <= ST_IDLE;
      count         <= 10'h000;
      RWW_BUSY_FLAG <= 1'b0;
      PROG_START    <= 1'b0;
      LOAD_GRANT    <= 1'b0;
      LOAD_BLOCKED  <= 1'b0;
      CORE_STALL    <= 1'b0;
      IRQ_MASK      <= 1'b0;
      APP_LOCK      <= LOCK_RESET;
      BOOT_LOCK     <= LOCK_RESET;
    end else begin
      state         <= next_state;
      count         <= next_count;
      RWW_BUSY_FLAG <= next_busy;
      PROG_START    <= next_start;
      LOAD_GRANT    <= next_lgrant;
      LOAD_BLOCKED  <= next_lblock;
      CORE_STALL    <= next_stall;
      IRQ_MASK      <= next_irq;
      APP_LOCK      <= next_app_lock;
      BOOT_LOCK     <= next_boot_lock;
    end
  end

  chk_app_store_ignored: assert property (@(posedge CLOCK) disable iff (SRST)
    (STORE_REQ && !exec_loader && state == ST_IDLE) |=> !PROG_START) // [RL1]
    else $error("store from application started programming");
  chk_halt_stall_span: assert property (@(posedge CLOCK) disable iff (SRST)
    (PROG_START && CORE_STALL) |-> CORE_STALL[*8]) // [RL5]
    else $error("halting programming stall dropped early");
  chk_conc_no_stall: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_PROG_CONC) |-> !CORE_STALL) // [RL4]
    else $error("core stalled during concurrent programming");
  chk_busy_during_conc: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_PROG_CONC) |-> RWW_BUSY_FLAG) // [RL7]
    else $error("busy flag low while concurrent region blocked");
  chk_lock_monotone: assert property (@(posedge CLOCK) disable iff (SRST)
    !$past(CHIP_ERASE) |-> ((APP_LOCK & ~$past(APP_LOCK)) == 2'h0)) // [RL11]
    else $error("app lock moved toward unprogrammed without erase");
  chk_boot_write_lock: assert property (@(posedge CLOCK) disable iff (SRST)
    (STORE_REQ && tgt_loader && !BOOT_LOCK[0]) |=> !PROG_START) // [RL19]
    else $error("store into write-locked loader region");
  chk_app_write_lock: assert property (@(posedge CLOCK) disable iff (SRST)
    (STORE_REQ && !tgt_loader && !APP_LOCK[0]) |=> !PROG_START) // [RL14]
    else $error("store into write-locked application region");
  chk_boot_read_lock: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_IDLE && !STORE_REQ && LOAD_REQ && !exec_loader && tgt_loader
     && !BOOT_LOCK[1]) |=> (LOAD_BLOCKED && !LOAD_GRANT)) // [RL21]
    else $error("application read of read-locked loader region");
  chk_app_read_lock: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_IDLE && !STORE_REQ && LOAD_REQ && exec_loader && !tgt_loader
     && !APP_LOCK[1]) |=> (LOAD_BLOCKED && !LOAD_GRANT)) // [RL16]
    else $error("loader read of read-locked application region");

  // loader placement: any fuse choice keeps the loader in the halting region
  chk_loader_in_halt: assert property (@(posedge CLOCK) disable iff (SRST)
    exec_loader |-> exec_halting) // [RL9]
    else $error("loader address outside halting region");

  // boot lock pair obeys the same one-way rule as the app pair
  chk_boot_lock_monotone: assert property (@(posedge CLOCK) disable iff (SRST)
    !$past(CHIP_ERASE) |-> ((BOOT_LOCK & ~$past(BOOT_LOCK)) == 2'h0)) // [RL11]
    else $error("boot lock moved toward unprogrammed without erase");

  // chip erase is the way back to unprogrammed
  chk_erase_restores: assert property (@(posedge CLOCK) disable iff (SRST)
    CHIP_ERASE |=> (APP_LOCK == LOCK_RESET && BOOT_LOCK == LOCK_RESET)) // [RL11]
    else $error("chip erase did not restore lock bits");

  // an all-ones mask for one pair leaves that pair alone
  chk_lock_independent: assert property (@(posedge CLOCK) disable iff (SRST)
    (LOCK_SET && !CHIP_ERASE && LOCK_SET_APP == 2'h3) |=> $stable(APP_LOCK)) // [RL10]
    else $error("boot lock setting disturbed app lock");

  // stall output mirrors the halting operation exactly
  chk_halt_stall_level: assert property (@(posedge CLOCK) disable iff (SRST)
    CORE_STALL == (state == ST_PROG_HALT)) // [RL5]
    else $error("stall level differs from halting operation");

  // nothing is read while the halting region is being programmed
  chk_halt_no_load: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_PROG_HALT) |=> !LOAD_GRANT) // [RL5]
    else $error("load granted during halting programming");

  // an allowed store from loader code in idle does start programming
  chk_loader_store_go: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_IDLE && STORE_REQ && exec_loader && !tgt_loader
     && !write_locked(APP_LOCK)) |=> PROG_START) // [RL2]
    else $error("allowed loader store did not start");

  // a busy set in the same cycle as a clear request wins
  chk_busy_set_wins: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == ST_IDLE && STORE_REQ && store_ok && !tgt_halting) |=> RWW_BUSY_FLAG) // [RL7]
    else $error("busy flag not set by concurrent programming");
endmodule
`default_nettype wire

// ### hw/region_decode.sv
// region decoder: classifies a flash word address by loader and halting region
// assumes boot_size_fuses are stable while in use
`timescale 1ns/1ps
`default_nettype none
module region_decode
  import flash_guard_pkg::*;
(
  input  wire logic [1:0]  boot_size,
  input  wire logic [12:0] addr,
  output logic             in_loader,
  output logic             in_halting
);
  logic [12:0] boot_start;
  // loader start from size fuses; every choice lies inside halting region
  always_comb begin
    case (boot_size)
      2'h3:    boot_start = BOOT_START_256;
      2'h2:    boot_start = BOOT_START_512;
      2'h1:    boot_start = BOOT_START_1K;
      default: boot_start = BOOT_START_2K;
    endcase
  end
  assign in_loader  = (addr >= boot_start);
  assign in_halting = (addr >= HALT_REGION_START);
endmodule
`default_nettype wire
